// [hw/rcpf_engine.sv]
/*
 Copy and fill engine: AHB-Lite register slave and a pixel-at-a-time walker.
 Assumes memory holds a request until a mem_ack pulse carrying read data.
 Pixel address is y * PITCH + x.
*/
// Function
// RULE1: copy reads source rectangle, writes destination
// RULE2: software programs pixel control A000H
// RULE3: software sets command bit 6
// RULE4: copy correct for overlapping or disjoint rectangles
// RULE5: software picks X direction for overlap
// RULE6: software picks Y direction for overlap
// RULE7: mix 0067H copies memory pixel unchanged
// RULE8: start, destination, size from packed registers
// RULE9: opcode 110 with draw starts copy
// RULE10: opcode 111 starts pattern fill
// RULE11: plane read is AND of enabled planes
// RULE12: read bit picks foreground or background mix
// RULE13: read mask samples, write mask updates planes
// RULE14: software sets multi-pixel bit for planes
// RULE15: mix 0002H gives one, 0001H zero
// RULE16: mono expansion writes foreground or background index
// RULE17: fill tiles 8x8 pattern over rectangle
// RULE18: tiles align to 8 of X, clipped
// RULE19: software keeps fill clear of pattern
// RULE20: write mask changes only by software write
// RULE21: whole-pixel color changes only through mix
// RULE22: software polls busy bit 9 first
// RULE23: busy holds until last pixel written
`timescale 1ns/1ns
module rcpf_engine
#(
   parameter int PITCH = 1024
)
(
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic [31:0]                        hrdata,
   output rcpf_pkg::rcpf_memreq_t             mem_o,
   input  wire logic [rcpf_pkg::PIX_W-1:0]    mem_rdata,
   input  wire logic                          mem_ack,
   output logic                               busy
);
   // ********
   // State
   // ********
   typedef struct packed {
      rcpf_pkg::rcpf_st_t         st;
      logic                       busy;
      logic                       is_fill;
      rcpf_pkg::rcpf_regs_t       regs;
      logic [15:0]                sx;
      logic [15:0]                sy;
      logic [15:0]                sx0;
      logic [15:0]                sy0;
      logic [15:0]                dx;
      logic [15:0]                dy;
      logic [15:0]                dx0;
      logic [15:0]                wcnt;
      logic [15:0]                hcnt;
      logic [rcpf_pkg::PIX_W-1:0] src_px;
      logic                       ap_valid;
      logic                       ap_write;
      logic [15:0]                ap_addr;
      logic [31:0]                hrdata;
      logic                       hreadyout;
      rcpf_pkg::rcpf_memreq_t     mem;
   } rcpf_state_t;

   rcpf_state_t s_r;
   rcpf_state_t s_nxt;

   logic [rcpf_pkg::PIX_W-1:0] mix_new;
   logic [rcpf_pkg::PIX_W-1:0] mix_out;
   logic [15:0]                mix_sel;
   logic                       plane_bit;

   // ********
   // Helpers
   // ********
   function automatic logic [rcpf_pkg::ADDR_W-1:0] pix_addr(
      input logic [15:0] x,
      input logic [15:0] y
   );
      logic [47:0] full;
      full = 48'(y) * 48'(PITCH) + 48'(x);
      return full[rcpf_pkg::ADDR_W-1:0];
   endfunction

   function automatic logic [15:0] step16(
      input logic [15:0] v,
      input logic        pos
   );
      return pos ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
   endfunction

   function automatic logic [31:0] reg_read(
      input rcpf_pkg::rcpf_regs_t r,
      input logic                 bsy,
      input logic [15:0]          a
   );
      logic [31:0] d;
      d = 32'h00000000;
      case (a)
         rcpf_pkg::OFF_CMD:       d[rcpf_pkg::STAT_BUSY_BIT] = bsy;
         rcpf_pkg::OFF_PLANE_WRITE_ENABLE_MASK:  d = r.plane_write_enable_mask;
         rcpf_pkg::OFF_RD_MASK:   d = r.rd_mask;
         rcpf_pkg::OFF_PIX_CNTL:  d = {16'h0000, r.pix_cntl};
         rcpf_pkg::OFF_FG_MIX:    d = {16'h0000, r.fg_mix};
         rcpf_pkg::OFF_BG_MIX:    d = {16'h0000, r.bg_mix};
         rcpf_pkg::OFF_MIX_PAIR:  d = {r.fg_mix, r.bg_mix};
         rcpf_pkg::OFF_CUR_POS:   d = r.cur_pos;
         rcpf_pkg::OFF_STEP_DST:  d = r.step_dst;
         rcpf_pkg::OFF_PIX_COUNT: d = r.pix_count;
         rcpf_pkg::OFF_FG_COLOR:  d = r.fg_color;
         rcpf_pkg::OFF_BG_COLOR:  d = r.bg_color;
         default:                 d = 32'h00000000;
      endcase
      return d;
   endfunction

   // ********
   // Pixel datapath
   // ********
   // Source bit is one only if every read-enabled plane is one
   assign plane_bit = &(s_r.src_px | ~s_r.regs.rd_mask[rcpf_pkg::PIX_W-1:0]); // RULE11

   always_comb
   begin
      if (s_r.regs.pix_cntl[rcpf_pkg::PIXC_SEL_MSB:rcpf_pkg::PIXC_SEL_LSB]
          == rcpf_pkg::PIXC_SEL_MEM)
      begin
         mix_sel = plane_bit ? s_r.regs.fg_mix : s_r.regs.bg_mix; // RULE12
      end
      else
      begin
         mix_sel = s_r.regs.fg_mix; // RULE21
      end
      case (mix_sel[rcpf_pkg::MIX_CSRC_MSB:rcpf_pkg::MIX_CSRC_LSB])
         rcpf_pkg::CSRC_MEM: mix_new = s_r.src_px; // RULE7
         rcpf_pkg::CSRC_FG:  mix_new = s_r.regs.fg_color[rcpf_pkg::PIX_W-1:0]; // RULE16
         rcpf_pkg::CSRC_BG:  mix_new = s_r.regs.bg_color[rcpf_pkg::PIX_W-1:0]; // RULE16
         default:            mix_new = s_r.src_px;
      endcase
   end

   rcpf_mix u_mix
   (
      .new_px (mix_new),
      .dst_px (mem_rdata),
      .fn     (mix_sel[rcpf_pkg::MIX_FN_MSB:0]),
      .result (mix_out)
   );

   // ********
   // Next state
   // ********
   always_comb
   begin
      logic        start;
      logic [2:0]  op;
      logic [15:0] wd;
      logic [15:0] rx;
      logic [15:0] ry;
      logic        xpos;
      logic        ypos;
      start = 1'b0;
      rx    = 16'h0000;
      ry    = 16'h0000;
      op    = hwdata[rcpf_pkg::CMD_OP_MSB:rcpf_pkg::CMD_OP_LSB];
      wd    = hwdata[15:0];
      s_nxt = s_r;
      xpos  = s_r.regs.cmd[rcpf_pkg::CMD_XPOS_BIT];
      ypos  = s_r.regs.cmd[rcpf_pkg::CMD_YPOS_BIT];
      s_nxt.hreadyout = 1'b1;

      // Data phase of a write; the bus never stalls
      if (s_r.ap_valid && s_r.ap_write)
      begin
         case (s_r.ap_addr)
            rcpf_pkg::OFF_CMD:
            begin
               // A command written while busy is dropped
               if (!s_r.busy)
               begin
                  s_nxt.regs.cmd = wd;
                  if (op == rcpf_pkg::OP_COPY && wd[rcpf_pkg::CMD_DRAW_BIT])
                  begin
                     start = 1'b1; // RULE9
                  end
                  else if (op == rcpf_pkg::OP_FILL)
                  begin
                     start = 1'b1; // RULE10
                  end
               end
            end
            rcpf_pkg::OFF_PLANE_WRITE_ENABLE_MASK:  s_nxt.regs.plane_write_enable_mask = hwdata; // RULE20
            rcpf_pkg::OFF_RD_MASK:   s_nxt.regs.rd_mask = hwdata;
            rcpf_pkg::OFF_PIX_CNTL:  s_nxt.regs.pix_cntl = wd;
            rcpf_pkg::OFF_FG_MIX:    s_nxt.regs.fg_mix = wd;
            rcpf_pkg::OFF_BG_MIX:    s_nxt.regs.bg_mix = wd;
            rcpf_pkg::OFF_MIX_PAIR:
            begin
               s_nxt.regs.fg_mix = hwdata[rcpf_pkg::XY_HI_MSB:rcpf_pkg::XY_HI_LSB];
               s_nxt.regs.bg_mix = wd;
            end
            rcpf_pkg::OFF_CUR_POS:   s_nxt.regs.cur_pos = hwdata;
            rcpf_pkg::OFF_STEP_DST:  s_nxt.regs.step_dst = hwdata;
            rcpf_pkg::OFF_PIX_COUNT: s_nxt.regs.pix_count = hwdata;
            rcpf_pkg::OFF_FG_COLOR:  s_nxt.regs.fg_color = hwdata;
            rcpf_pkg::OFF_BG_COLOR:  s_nxt.regs.bg_color = hwdata;
            default: s_nxt.regs = s_r.regs;
         endcase
      end

      // Drawing walker
      case (s_r.st)
         rcpf_pkg::ST_IDLE:
         begin
            if (start)
            begin
               s_nxt.busy    = 1'b1; // RULE23
               s_nxt.is_fill = (op == rcpf_pkg::OP_FILL);
               s_nxt.sx  = s_r.regs.cur_pos[rcpf_pkg::XY_HI_MSB:rcpf_pkg::XY_HI_LSB]; // RULE8
               s_nxt.sy  = s_r.regs.cur_pos[rcpf_pkg::XY_LO_MSB:0];
               s_nxt.sx0 = s_r.regs.cur_pos[rcpf_pkg::XY_HI_MSB:rcpf_pkg::XY_HI_LSB];
               s_nxt.sy0 = s_r.regs.cur_pos[rcpf_pkg::XY_LO_MSB:0];
               s_nxt.dx  = s_r.regs.step_dst[rcpf_pkg::XY_HI_MSB:rcpf_pkg::XY_HI_LSB];
               s_nxt.dy  = s_r.regs.step_dst[rcpf_pkg::XY_LO_MSB:0];
               s_nxt.dx0 = s_r.regs.step_dst[rcpf_pkg::XY_HI_MSB:rcpf_pkg::XY_HI_LSB];
               s_nxt.wcnt = 16'h0000;
               s_nxt.hcnt = 16'h0000;
               s_nxt.st   = rcpf_pkg::ST_RSRC;
            end
         end
         rcpf_pkg::ST_RSRC:
         begin
            // Pattern texel follows destination X and Y modulo the tile
            if (s_r.is_fill)
            begin
               rx = 16'(s_r.sx0 + {13'h0000, s_r.dx[2:0] & rcpf_pkg::PAT_COL_MASK}); // RULE18
               ry = 16'(s_r.sy0 + {13'h0000, s_r.dy[2:0] & rcpf_pkg::PAT_COL_MASK}); // RULE17
            end
            else
            begin
               rx = s_r.sx;
               ry = s_r.sy;
            end
            s_nxt.mem.req  = 1'b1;
            s_nxt.mem.we   = 1'b0;
            s_nxt.mem.addr = pix_addr(rx, ry); // RULE1
            if (s_r.mem.req && mem_ack)
            begin
               s_nxt.src_px   = mem_rdata;
               s_nxt.mem.req  = 1'b1;
               s_nxt.mem.addr = pix_addr(s_r.dx, s_r.dy);
               s_nxt.st       = rcpf_pkg::ST_RDST;
            end
         end
         rcpf_pkg::ST_RDST:
         begin
            if (mem_ack)
            begin
               // Destination just read feeds the mix directly
               s_nxt.mem.we    = 1'b1;
               s_nxt.mem.wdata = mix_out;
               s_nxt.mem.wmask = s_r.regs.plane_write_enable_mask[rcpf_pkg::PIX_W-1:0]; // RULE13
               s_nxt.st        = rcpf_pkg::ST_WR;
            end
         end
         rcpf_pkg::ST_WR:
         begin
            if (mem_ack)
            begin
               s_nxt.mem.req = 1'b0;
               s_nxt.mem.we  = 1'b0;
               // Walk order follows software's direction bits for overlap
               if (s_r.wcnt == s_r.regs.pix_count[rcpf_pkg::XY_HI_MSB:rcpf_pkg::XY_HI_LSB])
               begin
                  s_nxt.wcnt = 16'h0000;
                  s_nxt.sx   = s_r.sx0;
                  s_nxt.dx   = s_r.dx0;
                  s_nxt.sy   = step16(s_r.sy, ypos); // RULE4
                  s_nxt.dy   = step16(s_r.dy, ypos);
                  s_nxt.hcnt = 16'(s_r.hcnt + 16'h0001);
                  if (s_r.hcnt == s_r.regs.pix_count[rcpf_pkg::XY_LO_MSB:0])
                  begin
                     s_nxt.busy = 1'b0; // RULE23
                     s_nxt.st   = rcpf_pkg::ST_IDLE;
                  end
                  else
                  begin
                     s_nxt.st = rcpf_pkg::ST_RSRC;
                  end
               end
               else
               begin
                  s_nxt.wcnt = 16'(s_r.wcnt + 16'h0001);
                  s_nxt.sx   = step16(s_r.sx, xpos); // RULE4
                  s_nxt.dx   = step16(s_r.dx, xpos);
                  s_nxt.st   = rcpf_pkg::ST_RSRC;
               end
            end
         end
         default:
         begin
            s_nxt.st      = rcpf_pkg::ST_IDLE;
            s_nxt.busy    = 1'b0;
            s_nxt.mem.req = 1'b0;
         end
      endcase

      // Address phase; read data sees any write landing this cycle
      s_nxt.ap_valid = hsel && hready && (htrans == rcpf_pkg::HTRANS_NONSEQ);
      s_nxt.ap_write = hwrite;
      s_nxt.ap_addr  = haddr[15:0];
      if (hsel && hready && (htrans == rcpf_pkg::HTRANS_NONSEQ) && !hwrite)
      begin
         s_nxt.hrdata = reg_read(s_nxt.regs, s_nxt.busy, haddr[15:0]);
      end
   end

   // ********
   // Registers
   // ********
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r                <= '0;
         s_r.st             <= rcpf_pkg::ST_IDLE;
         s_r.regs.plane_write_enable_mask  <= rcpf_pkg::RST_PLANE_WRITE_ENABLE_MASK;
         s_r.regs.rd_mask   <= rcpf_pkg::RST_RD_MASK;
         s_r.regs.pix_cntl  <= rcpf_pkg::RST_PIX_CNTL;
         s_r.regs.fg_mix    <= rcpf_pkg::RST_FG_MIX;
         s_r.regs.bg_mix    <= rcpf_pkg::RST_BG_MIX;
         s_r.hreadyout      <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout = s_r.hreadyout;
   assign hresp     = 1'b0;
   assign hrdata    = s_r.hrdata;
   assign mem_o     = s_r.mem;
   assign busy      = s_r.busy;
endmodule

// [hw/rcpf_pkg.sv]
/*
 Copy and fill engine package: offsets, fields, reset values, states, types.
 Assumes a 32-bit AHB-Lite bus and a pixel-wide display memory port.
*/
package rcpf_pkg;
   // ********
   // Sizes
   // ********
   localparam int PIX_W  = 8;
   localparam int ADDR_W = 22;
   localparam int PAT_DIM = 8;
   localparam logic [2:0] PAT_COL_MASK = 3'h7;

   // ********
   // Register byte offsets
   // ********
   localparam logic [15:0] OFF_CMD       = 16'h9ae8;
   localparam logic [15:0] OFF_PLANE_WRITE_ENABLE_MASK  = 16'haae8;
   localparam logic [15:0] OFF_RD_MASK   = 16'haee8;
   localparam logic [15:0] OFF_PIX_CNTL  = 16'hbee8;
   localparam logic [15:0] OFF_FG_MIX    = 16'hbae8;
   localparam logic [15:0] OFF_BG_MIX    = 16'hb6e8;
   localparam logic [15:0] OFF_MIX_PAIR  = 16'h8134;
   localparam logic [15:0] OFF_CUR_POS   = 16'h8100;
   localparam logic [15:0] OFF_STEP_DST  = 16'h8108;
   localparam logic [15:0] OFF_PIX_COUNT = 16'h8148;
   localparam logic [15:0] OFF_FG_COLOR  = 16'ha6e8;
   localparam logic [15:0] OFF_BG_COLOR  = 16'ha2e8;

   // ********
   // Field positions and codes
   // ********
   localparam int CMD_OP_MSB    = 15;
   localparam int CMD_OP_LSB    = 13;
   localparam int CMD_YPOS_BIT  = 7;
   localparam int CMD_XPOS_BIT  = 5;
   localparam int CMD_DRAW_BIT  = 4;
   localparam int STAT_BUSY_BIT = 9;
   localparam logic [2:0] OP_COPY = 3'h6;
   localparam logic [2:0] OP_FILL = 3'h7;
   localparam int PIXC_SEL_MSB = 7;
   localparam int PIXC_SEL_LSB = 6;
   localparam logic [1:0] PIXC_SEL_MEM = 2'h3;
   localparam int MIX_CSRC_MSB = 6;
   localparam int MIX_CSRC_LSB = 5;
   localparam int MIX_FN_MSB   = 3;
   localparam logic [1:0] CSRC_BG  = 2'h0;
   localparam logic [1:0] CSRC_FG  = 2'h1;
   localparam logic [1:0] CSRC_MEM = 2'h3;
   localparam int XY_HI_MSB = 31;
   localparam int XY_HI_LSB = 16;
   localparam int XY_LO_MSB = 15;

   // ********
   // Reset values
   // ********
   localparam logic [31:0] RST_PLANE_WRITE_ENABLE_MASK = 32'hffffffff;
   localparam logic [31:0] RST_RD_MASK  = 32'hffffffff;
   localparam logic [15:0] RST_PIX_CNTL = 16'ha000;
   localparam logic [15:0] RST_FG_MIX   = 16'h0067;
   localparam logic [15:0] RST_BG_MIX   = 16'h0007;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // ********
   // Types
   // ********
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RSRC = 4'h2,
      ST_RDST = 4'h4,
      ST_WR   = 4'h8
   } rcpf_st_t;

   typedef struct packed {
      logic              req;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [PIX_W-1:0]  wdata;
      logic [PIX_W-1:0]  wmask;
   } rcpf_memreq_t;

   typedef struct packed {
      logic [31:0] plane_write_enable_mask;
      logic [31:0] rd_mask;
      logic [15:0] pix_cntl;
      logic [15:0] cmd;
      logic [15:0] fg_mix;
      logic [15:0] bg_mix;
      logic [31:0] cur_pos;
      logic [31:0] step_dst;
      logic [31:0] pix_count;
      logic [31:0] fg_color;
      logic [31:0] bg_color;
   } rcpf_regs_t;
endpackage

// [hw/rcpf_mix.sv]
/*
 Raster mix unit: combines a new color with the destination pixel by one of
 sixteen mix functions. Purely combinational; caller registers the result.
*/
`timescale 1ns/1ns
module rcpf_mix
(
   input  wire logic [rcpf_pkg::PIX_W-1:0] new_px,
   input  wire logic [rcpf_pkg::PIX_W-1:0] dst_px,
   input  wire logic [3:0]                 fn,
   output logic      [rcpf_pkg::PIX_W-1:0] result
);
   always_comb
   begin
      case (fn)
         4'h0: result = ~dst_px;
         4'h1: result = '0;              // RULE15
         4'h2: result = '1;              // RULE15
         4'h3: result = dst_px;
         4'h4: result = ~new_px;
         4'h5: result = new_px ^ dst_px;
         4'h6: result = ~(new_px ^ dst_px);
         4'h7: result = new_px;          // RULE7
         4'h8: result = ~new_px | ~dst_px;
         4'h9: result = ~new_px | dst_px;
         4'ha: result = new_px | ~dst_px;
         4'hb: result = new_px | dst_px;
         4'hc: result = new_px & dst_px;
         4'hd: result = ~new_px & dst_px;
         4'he: result = new_px & ~dst_px;
         default: result = ~new_px & ~dst_px;
      endcase
   end
endmodule

// [verification/rcpf_engine_sva.sv]
/*
 Concurrent checks for the copy and fill engine, bound to its top module.
 Assumes registers are rewritten only while the engine is idle.
*/
`timescale 1ns/1ns
module rcpf_engine_sva
#(
   parameter int PITCH = 1024
)
(
   input wire logic                       hclk,
   input wire logic                       hresetn,
   input wire logic                       hsel,
   input wire logic [31:0]                haddr,
   input wire logic [1:0]                 htrans,
   input wire logic                       hwrite,
   input wire logic [31:0]                hwdata,
   input wire logic                       hready,
   input wire logic                       hreadyout,
   input wire logic                       hresp,
   input wire rcpf_pkg::rcpf_memreq_t     mem_o,
   input wire logic                       mem_ack,
   input wire logic                       busy
);
   logic        wr_ph;
   logic        cmd_ph_r;
   logic        cur_ph_r;
   logic        wm_ph_r;
   logic        copy_r;
   logic [31:0] cur_r;
   logic [7:0]  wm_r;
   logic [21:0] src_a;
   logic [2:0]  op;

   assign wr_ph = hsel && hready && htrans == rcpf_pkg::HTRANS_NONSEQ && hwrite;
   assign src_a = 22'(cur_r[15:0]) * 22'(PITCH) + 22'(cur_r[31:16]);
   assign op    = hwdata[15:13];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cmd_ph_r <= 1'b0;
         cur_ph_r <= 1'b0;
         wm_ph_r  <= 1'b0;
         copy_r   <= 1'b0;
         cur_r    <= 32'h0;
         wm_r     <= rcpf_pkg::RST_PLANE_WRITE_ENABLE_MASK[7:0];
      end
      else
      begin
         cmd_ph_r <= wr_ph && haddr[15:0] == rcpf_pkg::OFF_CMD;
         cur_ph_r <= wr_ph && haddr[15:0] == rcpf_pkg::OFF_CUR_POS;
         wm_ph_r  <= wr_ph && haddr[15:0] == rcpf_pkg::OFF_PLANE_WRITE_ENABLE_MASK;
         if (cmd_ph_r && !busy)
            copy_r <= op == rcpf_pkg::OP_COPY;
         if (cur_ph_r)
            cur_r <= hwdata;
         if (wm_ph_r)
            wm_r <= hwdata[7:0];
      end
   end

   // ********
   // Assertions
   // ********
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   copy_start_a: assert property (cmd_ph_r && !busy && op == rcpf_pkg::OP_COPY
      && hwdata[4] |=> busy) else $error("Copy command did not start");
   no_draw_a: assert property (cmd_ph_r && !busy && op == rcpf_pkg::OP_COPY
      && !hwdata[4] |=> !busy) else $error("Copy without draw bit started");
   fill_start_a: assert property (cmd_ph_r && !busy && op == rcpf_pkg::OP_FILL
      |=> busy) else $error("Fill command did not start");
   req_busy_a: assert property (mem_o.req |-> busy)
      else $error("Memory request outside busy");
   busy_end_a: assert property ($fell(busy) |-> $past(mem_ack) && $past(mem_o.we))
      else $error("Busy dropped before last write");
   req_stand_a: assert property (mem_o.req && !mem_ack |=> $stable(mem_o))
      else $error("Memory request changed before ack");
   first_read_a: assert property ($rose(busy) && copy_r |-> ##[0:2]
      (mem_o.req && !mem_o.we && mem_o.addr == src_a)) else $error("First read not at source");
   write_mask_a: assert property (mem_o.req && mem_o.we |-> mem_o.wmask == wm_r)
      else $error("Write plane mask differs from register");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("Bus stalled or answered with error");

   cover property ($rose(busy) && copy_r);
   cover property ($rose(busy) && !copy_r);
   cover property (mem_o.req && mem_o.we && mem_o.wmask != 8'hff);
endmodule

bind rcpf_engine rcpf_engine_sva #(.PITCH(PITCH)) rcpf_engine_sva_i
(
   .hclk      (hclk),
   .hresetn   (hresetn),
   .hsel      (hsel),
   .haddr     (haddr),
   .htrans    (htrans),
   .hwrite    (hwrite),
   .hwdata    (hwdata),
   .hready    (hready),
   .hreadyout (hreadyout),
   .hresp     (hresp),
   .mem_o     (mem_o),
   .mem_ack   (mem_ack),
   .busy      (busy)
);

// [verification/test_rect_copy_and_pattern_fill_engine.sv]
/*
 Copy and fill bench: bus tasks, random-delay memory, pixel model.
 Assumes PITCH 16: pixel (x,y) at byte y*16+x.
*/
`timescale 1ns/1ns
module test_rect_copy_and_pattern_fill_engine;
   localparam int P = 16;
   logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
   logic [31:0]            haddr, hwdata, hrdata, q;
   logic [1:0]             htrans;
   logic [2:0]             hsize;
   logic                   mem_ack = 1'b0;
   logic [1:0]             wcnt = 2'h0;
   logic [7:0]             mem_rdata = 8'h00;
   logic [7:0]             mem [256];
   logic [7:0]             ex [256];
   rcpf_pkg::rcpf_memreq_t mem_o;
   integer                 seed = 6, error_cnt = 0, samples_checked = 0, cyc = 0;

   rcpf_engine #(.PITCH(P)) rcpf_engine_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .mem_o(mem_o), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));

   always #4 hclk = ~hclk;

   // ********
   // Display memory, random answer delay
   // ********
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mem_ack <= 1'b0;
      else if (mem_ack)
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wcnt      <= 2'($random(seed));
      end
      else if (mem_o.req && wcnt == 2'h0)
      begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem[mem_o.addr[7:0]];
         if (mem_o.we)
            mem[mem_o.addr[7:0]] <= (mem[mem_o.addr[7:0]] & ~mem_o.wmask)
                                    | (mem_o.wdata & mem_o.wmask);
      end
      else if (mem_o.req)
         wcnt <= wcnt - 2'h1;
   end

   always @(posedge hclk)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt = error_cnt + 1;
         tally_and_finish();
      end
   end

   // ********
   // Tasks and model
   // ********
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= rcpf_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= {16'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   // Fixed colours: foreground index 4, background index 1
   function automatic logic [7:0] mix_px(input logic [15:0] pc, input logic [31:0] mp,
                                         input logic [31:0] rm, input logic [7:0] s);
      logic [15:0] m;
      m = (pc[7:6] == 2'h3 && (s & rm[7:0]) != rm[7:0]) ? mp[15:0] : mp[31:16];
      case (m[3:0])
         4'h1: return 8'h00;
         4'h2: return 8'hff;
         default: return m[6:5] == 2'h0 ? 8'h01 : m[6:5] == 2'h1 ? 8'h04 : s;
      endcase
   endfunction

   task automatic run_op(input logic [15:0] cmd, input logic [15:0] pc, input logic [31:0] mp,
                         input logic [31:0] rm, input logic [31:0] wm, input logic [31:0] cur,
                         input logic [31:0] stp, input logic [31:0] cnt);
      int   sx, sy, dx, dy;
      logic fill;
      logic drw;
      fill = cmd[15:13] == rcpf_pkg::OP_FILL;
      drw  = fill || (cmd[15:13] == rcpf_pkg::OP_COPY && cmd[4]);
      for (int i = 0; i < 256; i++)
      begin
         mem[i] = 8'($random(seed));
         ex[i]  = mem[i];
      end
      for (int j = 0; drw && j <= int'(cnt[15:0]); j++)
         for (int i = 0; i <= int'(cnt[31:16]); i++)
         begin
            dx = cmd[5] ? stp[31:16] + i : stp[31:16] - i;
            dy = cmd[7] ? stp[15:0] + j : stp[15:0] - j;
            sx = fill ? cur[31:16] + dx % 8 : (cmd[5] ? cur[31:16] + i : cur[31:16] - i);
            sy = fill ? cur[15:0] + dy % 8 : (cmd[7] ? cur[15:0] + j : cur[15:0] - j);
            ex[dy*P+dx] = (mem[dy*P+dx] & ~wm[7:0]) | (mix_px(pc, mp, rm, mem[sy*P+sx]) & wm[7:0]);
         end
      ahb(1'b1, rcpf_pkg::OFF_PIX_CNTL, {16'h0, pc});
      ahb(1'b1, rcpf_pkg::OFF_MIX_PAIR, mp);
      ahb(1'b1, rcpf_pkg::OFF_RD_MASK, rm);
      ahb(1'b1, rcpf_pkg::OFF_PLANE_WRITE_ENABLE_MASK, wm);
      ahb(1'b1, rcpf_pkg::OFF_FG_COLOR, 32'h4);
      ahb(1'b1, rcpf_pkg::OFF_BG_COLOR, 32'h1);
      ahb(1'b1, rcpf_pkg::OFF_CUR_POS, cur);
      ahb(1'b1, rcpf_pkg::OFF_STEP_DST, stp);
      ahb(1'b1, rcpf_pkg::OFF_PIX_COUNT, cnt);
      ahb(1'b1, rcpf_pkg::OFF_CMD, {16'h0, cmd});
      ahb(1'b0, rcpf_pkg::OFF_CMD, 32'h0);
      chk32(q & 32'h200, {22'h0, drw, 9'h0});
      while (q[rcpf_pkg::STAT_BUSY_BIT] !== 1'b0)
         ahb(1'b0, rcpf_pkg::OFF_CMD, 32'h0);
      for (int i = 0; i < 256; i++)
         chk32({24'h0, mem[i]}, {24'h0, ex[i]});
      ahb(1'b0, rcpf_pkg::OFF_PLANE_WRITE_ENABLE_MASK, 32'h0);
      chk32(q, wm);
   endtask

   task automatic tally_and_finish;
      if (error_cnt == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ********
   // Main sequence
   // ********
   localparam logic [15:0] ROFF [5] = '{rcpf_pkg::OFF_PLANE_WRITE_ENABLE_MASK, rcpf_pkg::OFF_RD_MASK,
                                        rcpf_pkg::OFF_PIX_CNTL, rcpf_pkg::OFF_FG_MIX, 16'h0};
   localparam logic [31:0] RVAL [5] = '{32'hffffffff, 32'hffffffff, 32'ha000, 32'h67, 32'h0};

   initial
   begin
      logic [31:0] r;
      int          m;
      logic        f;
      hclk    = 1'b0;
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         ahb(1'b0, ROFF[k], 32'h0);
         chk32(q, RVAL[k]);
      end
      // Overlapping copies, all four walk directions
      for (int k = 0; k < 4; k++)
         run_op(16'hc051 | {8'h0, k[1], 1'b0, k[0], 5'h0}, 16'ha000, 32'h00670007, '1, '1,
                {k[0] ? 16'h5 : 16'h8, k[1] ? 16'h5 : 16'h8},
                {k[0] ? 16'h3 : 16'ha, k[1] ? 16'h3 : 16'ha}, 32'h00030003);
      // Copy without the draw bit leaves memory alone
      run_op(16'hc0e1, 16'ha000, 32'h00670007, '1, '1, 32'h0, 32'h00080008, 32'h00030003);
      // Whole-pixel, single plane and two-colour modes, copy then fill
      for (int k = 0; k < 12; k++)
      begin
         r = $random(seed);
         m = k % 3;
         f = (k % 6) > 2;
         run_op((f ? 16'he0f1 : 16'hc0f1) | (m != 0 ? 16'h2 : 16'h0),
                m == 0 ? 16'ha000 : 16'ha0c0,
                m == 0 ? 32'h00670007 : m == 1 ? 32'h00020001 : 32'h00270007,
                m == 0 ? '1 : (k < 6 ? 32'h1 : {24'h0, r[19:12]}),
                m == 1 ? (k < 6 ? 32'h4 : {24'h0, r[27:20]}) : '1,
                f ? 32'h0 : {14'h0, r[1:0], 14'h0, r[3:2]},
                {16'h8 + r[5:4], 16'h8 + r[7:6]},
                {f ? 16'h7 - r[5:4] : {14'h0, r[9:8]}, 14'h0, r[11:10]});
      end
      tally_and_finish();
   end
endmodule
